/* File: design/iosc_defines.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  internal oscillator control block.
  Assumes inclusion by bare name from design files.
*/
`ifndef IOSC_DEFINES_SVH
`define IOSC_DEFINES_SVH
`define IOSC_CTRL_ADDR      8'hb2
`define IOSC_BIT_EN         7
`define IOSC_BIT_RDY        6
`define IOSC_BIT_SLEEP      5
`define IOSC_BIT_SYNC       4
`define IOSC_BIT_DITHER     3
`define IOSC_BIT_UNUSED     2
`define IOSC_RST_EN         1'h1
`define IOSC_RST_RDY        1'h1
`define IOSC_RST_DITHER     1'h0
`define IOSC_RST_DIV        2'h0
`define IOSC_DITHER_PERIOD  9'h180
`define IOSC_DITHER_STEP    6'h20
`define IOSC_SYNC_CLOCKS    2'h3
`define IOSC_SETTLE_CYC     8'h10
`endif

/* File: design/iosc_pkg.sv */
/*
  Types of the internal oscillator control block.
  Assumes nothing of its surroundings.
*/
package iosc_pkg;
  // Oscillator condition, one-hot
  typedef enum logic [3:0] {
    IOSC_OFF    = 4'h1,
    IOSC_SETTLE = 4'h2,
    IOSC_RUN    = 4'h4,
    IOSC_SLEEP  = 4'h8
  } iosc_state_t;
  // External drive circuit modes (3-bit mode field of the ext control)
  typedef enum logic [2:0] {
    IOSC_XM_OFF   = 3'h0,
    IOSC_XM_CMOS  = 3'h2,
    IOSC_XM_CMOS2 = 3'h3,
    IOSC_XM_RC    = 3'h4,
    IOSC_XM_CAP   = 3'h5,
    IOSC_XM_XTAL  = 3'h6,
    IOSC_XM_CRYSTAL_OUTPUT_PIN = 3'h7
  } iosc_xmode_t;
endpackage

/* File: design/iosc_ctrl.sv */
/*
  Control and status register of the internal high-frequency oscillator,
  its settle/sleep sequencing, dither modulation and post-divider, and
  the pin claims of the external oscillator drive circuit.
  Assumes a one-clock special-function register port, wake events and
  a wake-timer tick synchronous to mclk, and an ext mode from outside.
*/
// What this block does
// - Enable bit runs oscillator, resets to one
// - Read-only ready flag, resets to one
// - Sleep request halts; wake events restart
// - Sync-busy flag up to three timer clocks
// - Dither enable bit, resets to zero
// - Triangle at osc/384, step every 32
// - Divider field 00=/8 ... 11=/1, reset 00
// - Bit 2 reads zero, writes ignored
// - Crystal modes claim both crystal pins
// - Capacitor, RC, CMOS claim output pin
`timescale 1ns/10ps
`include "iosc_defines.svh"
module iosc_ctrl (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,       // Register address
  input  wire logic       sfr_wr,         // Write strobe
  input  wire logic [7:0] sfr_wdata,      // Write data
  output logic      [7:0] sfr_rdata,      // Read data, registered
  input  wire logic       wake_event,     // Any wake-up event, pulse
  input  wire logic       wake_by_timer,  // Wake came from the timer
  input  wire logic       timer_tick,     // Wake-timer clock tick
  input  wire logic [2:0] ext_osc_mode,   // External drive circuit mode
  output logic            hf_osc_run,     // Oscillator running or settling
  output logic            dither_up,      // Modulation direction
  output logic      [1:0] dither_step,    // Stepped frequency offset
  output logic            system_clock,   // Divided clock enable
  output logic            claim_crystal_input_pin,
  output logic            claim_crystal_output_pin
);
  // Control fields
  logic       hf_osc_enable_r;
  logic       spread_dither_enable_r;
  logic [1:0] hf_divider_select_r;
  logic       hf_freq_ready_r;
  logic       wake_timer_sync_busy_r;
  logic [1:0] sync_cnt_r;              // Timer clocks left busy
  logic [7:0] settle_r;                // Settling count after start
  logic [8:0] tri_cnt_r;               // Position within triangle period
  logic [5:0] step_cnt_r;              // Cycles since last step
  logic [2:0] div_cnt_r;               // Post-divider counter
  iosc_pkg::iosc_state_t st_r;
  iosc_pkg::iosc_state_t st_nxt;

  // Decode of the register port
  wire hit_wr = sfr_wr && (sfr_addr == `IOSC_CTRL_ADDR);
  wire sleep_req = hit_wr && sfr_wdata[`IOSC_BIT_SLEEP];
  wire en_nxt = hit_wr ? sfr_wdata[`IOSC_BIT_EN] : hf_osc_enable_r;
  wire running = (st_r == iosc_pkg::IOSC_RUN);
  wire tri_wrap = (tri_cnt_r == `IOSC_DITHER_PERIOD - 9'h1);
  wire step_due = (step_cnt_r == `IOSC_DITHER_STEP - 6'h1);
  // First half of the period climbs, second half falls: six steps each
  wire rising_half = (tri_cnt_r < (`IOSC_DITHER_PERIOD >> 1));
  wire [7:0] rd_word = {hf_osc_enable_r, hf_freq_ready_r, 1'b0,
                        wake_timer_sync_busy_r, spread_dither_enable_r,
                        1'b0, hf_divider_select_r};
  // Divide terminal count: 00 -> 7 (/8), 01 -> 3 (/4), 10 -> 1 (/2), 11 -> 0 (/1)
  wire [2:0] div_last = 3'h7 >> hf_divider_select_r;
  wire xm_xtal = (ext_osc_mode == iosc_pkg::IOSC_XM_XTAL) ||
                 (ext_osc_mode == iosc_pkg::IOSC_XM_CRYSTAL_OUTPUT_PIN);
  wire xm_other = (ext_osc_mode == iosc_pkg::IOSC_XM_CMOS) ||
                  (ext_osc_mode == iosc_pkg::IOSC_XM_CMOS2) ||
                  (ext_osc_mode == iosc_pkg::IOSC_XM_RC) ||
                  (ext_osc_mode == iosc_pkg::IOSC_XM_CAP);

  // Oscillator sequencing; in settle and run sleep beats a simultaneous
  // wake, but a sleep request is ignored while off or asleep
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      iosc_pkg::IOSC_OFF:
        if (en_nxt) st_nxt = iosc_pkg::IOSC_SETTLE;
      iosc_pkg::IOSC_SETTLE:
        if (!en_nxt) st_nxt = iosc_pkg::IOSC_OFF;
        else if (sleep_req) st_nxt = iosc_pkg::IOSC_SLEEP;
        else if (settle_r == 8'h0) st_nxt = iosc_pkg::IOSC_RUN;
      iosc_pkg::IOSC_RUN:
        if (!en_nxt) st_nxt = iosc_pkg::IOSC_OFF;
        else if (sleep_req) st_nxt = iosc_pkg::IOSC_SLEEP;
      // Clearing the enable while asleep stops it for good, so a later
      // wake cannot start a disabled oscillator
      iosc_pkg::IOSC_SLEEP:
        if (!en_nxt) st_nxt = iosc_pkg::IOSC_OFF;
        else if (wake_event) st_nxt = iosc_pkg::IOSC_SETTLE;
    endcase
  end

  // State and settle counter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r     <= iosc_pkg::IOSC_RUN;  // Running at reset, ready high
      settle_r <= 8'h0;
    end
    else
    begin
      st_r     <= st_nxt;
      settle_r <= (st_nxt == iosc_pkg::IOSC_SETTLE && st_r != iosc_pkg::IOSC_SETTLE)
                  ? `IOSC_SETTLE_CYC : settle_r - {7'h0, settle_r != 8'h0};
    end
  end

  // Control fields; bit 2 and read-only bits are not stored
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hf_osc_enable_r        <= `IOSC_RST_EN;
      spread_dither_enable_r <= `IOSC_RST_DITHER;
      hf_divider_select_r    <= `IOSC_RST_DIV;
    end
    else if (hit_wr)
    begin
      hf_osc_enable_r        <= sfr_wdata[`IOSC_BIT_EN];
      spread_dither_enable_r <= sfr_wdata[`IOSC_BIT_DITHER];
      hf_divider_select_r    <= sfr_wdata[1:0];
    end
  end

  // Ready follows the settled state only
  always_ff @(posedge mclk)
  begin
    if (!rst_n) hf_freq_ready_r <= `IOSC_RST_RDY;
    else hf_freq_ready_r <= (st_nxt == iosc_pkg::IOSC_RUN);
  end

  // Sync busy: set on a wake not caused by the timer, held three ticks
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wake_timer_sync_busy_r <= 1'b0;
      sync_cnt_r             <= 2'h0;
    end
    else if (st_r == iosc_pkg::IOSC_SLEEP && wake_event && !wake_by_timer)
    begin
      wake_timer_sync_busy_r <= 1'b1;
      sync_cnt_r             <= `IOSC_SYNC_CLOCKS;
    end
    else if (wake_timer_sync_busy_r && timer_tick)
    begin
      sync_cnt_r             <= sync_cnt_r - 2'h1;
      wake_timer_sync_busy_r <= (sync_cnt_r != 2'h1);
    end
  end

  // Triangle generator: period 384 cycles, step every 32
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !spread_dither_enable_r || !running)
    begin
      tri_cnt_r   <= 9'h0;
      step_cnt_r  <= 6'h0;
      dither_step <= 2'h0;
      dither_up   <= 1'b1;
    end
    else
    begin
      tri_cnt_r  <= tri_wrap ? 9'h0 : tri_cnt_r + 9'h1;
      step_cnt_r <= step_due ? 6'h0 : step_cnt_r + 6'h1;
      // Twelve steps per period: six up, six down
      if (step_due)
      begin
        dither_up   <= rising_half || tri_wrap;
        dither_step <= rising_half ? dither_step + {1'b0, dither_step != 2'h3}
                       : dither_step - {1'b0, dither_step != 2'h0};
      end
    end
  end

  // Post-divider, pins, read data, run output
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_cnt_r    <= 3'h0;
      system_clock <= 1'b0;
      claim_crystal_input_pin  <= 1'b0;
      claim_crystal_output_pin <= 1'b0;
      sfr_rdata    <= 8'h0;
      hf_osc_run   <= 1'b1;
    end
    else
    begin
      div_cnt_r    <= (!running || div_cnt_r >= div_last) ? 3'h0 : div_cnt_r + 3'h1;
      system_clock <= running && (div_cnt_r >= div_last);
      claim_crystal_input_pin  <= xm_xtal;
      claim_crystal_output_pin <= xm_xtal || xm_other;
      sfr_rdata    <= (sfr_addr == `IOSC_CTRL_ADDR) ? rd_word : 8'h0;
      hf_osc_run   <= (st_nxt == iosc_pkg::IOSC_RUN) ||
                      (st_nxt == iosc_pkg::IOSC_SETTLE);
    end
  end

  a_ready_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !hf_osc_enable_r |-> ##1 !hf_freq_ready_r)
    else $error("ready high while disabled");
  a_sleep_halts: assert property (@(posedge mclk) disable iff (!rst_n)
    (running && sleep_req && sfr_wdata[`IOSC_BIT_EN]) |=> !hf_osc_run && !hf_freq_ready_r)
    else $error("sleep did not halt");
  a_wake_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r == iosc_pkg::IOSC_SLEEP && wake_event && !hit_wr) |=> hf_osc_run)
    else $error("wake did not restart");
  a_bit2_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    !sfr_rdata[`IOSC_BIT_UNUSED])
    else $error("bit 2 read nonzero");
  a_busy_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_r == iosc_pkg::IOSC_SLEEP && wake_event && !wake_by_timer) |=> wake_timer_sync_busy_r)
    else $error("sync busy not set");
  a_step_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(dither_step) && spread_dither_enable_r && running |-> step_cnt_r == 6'h0)
    else $error("dither step off grid");
  a_dither_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !spread_dither_enable_r |=> dither_step == 2'h0)
    else $error("dither active while off");
  a_div_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (running && hf_divider_select_r == 2'h3) [*2] |=> system_clock)
    else $error("divide by one stalled");
  a_pins_xtal: assert property (@(posedge mclk) disable iff (!rst_n)
    xm_xtal |=> claim_crystal_input_pin && claim_crystal_output_pin)
    else $error("crystal pins not claimed");
  c_sleep: cover property (@(posedge mclk) st_r == iosc_pkg::IOSC_SLEEP ##1 wake_event);
  c_busy: cover property (@(posedge mclk) $fell(wake_timer_sync_busy_r));
  c_dither: cover property (@(posedge mclk) dither_step == 2'h3);
  c_off: cover property (@(posedge mclk) $fell(hf_osc_enable_r));
  c_timer_wake: cover property (@(posedge mclk)
    st_r == iosc_pkg::IOSC_SLEEP && wake_event && wake_by_timer);
endmodule // iosc_ctrl

/* File: dv/iosc_xosc_model.sv */
/*
  Behavioural stand-in for the external drive source: crystal,
  resonator, RC network, capacitor or CMOS clock.
  Assumes the bench picks the source type through src_sel.
*/
`timescale 1ns/10ps
module iosc_xosc_model (
  input  wire logic       mclk,
  input  wire logic [2:0] src_sel,      // Source type chosen by software
  output logic      [2:0] ext_osc_mode, // Mode field seen by the block
  output logic            pins_analog   // Oscillator pins set as analog inputs
);
  // Type is settled in the mode field before the circuit is used
  always_ff @(posedge mclk)
  begin
    ext_osc_mode <= src_sel;
    // Crystal, RC and capacitor sources want analog pins, CMOS a digital one
    pins_analog  <= src_sel[2];
  end
endmodule // iosc_xosc_model

/* File: dv/tb.sv */
/*
  Self-checking bench of the internal oscillator control block.
  Assumes the design files and the drive-source model compile first.
*/
`timescale 1ns/10ps
module tb;
  logic       mclk = 0, rst_n = 0, sfr_wr = 0, wake_event = 0;
  logic       wake_by_timer = 0, timer_tick = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, rd;   // Bus drive, last read
  logic [7:0] sfr_rdata;
  logic       hf_osc_run, dither_up, system_clock, cin, cout, pins_analog;
  logic [1:0] dither_step, stp;                  // Step and its snapshot
  logic [2:0] ext_osc_mode, src_sel = 0;
  int         num_errors = 0, checked = 0, seed = 32'ha1647a7c, n, i, d;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  iosc_ctrl uut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wake_event(wake_event),
    .wake_by_timer(wake_by_timer), .timer_tick(timer_tick), .ext_osc_mode(ext_osc_mode),
    .hf_osc_run(hf_osc_run), .dither_up(dither_up), .dither_step(dither_step),
    .system_clock(system_clock), .claim_crystal_input_pin(cin),
    .claim_crystal_output_pin(cout));
  iosc_xosc_model src (.mclk(mclk), .src_sel(src_sel), .ext_osc_mode(ext_osc_mode),
    .pins_analog(pins_analog));
  // Compare and count
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One-cycle write, launched just after an edge
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(posedge mclk);
    #1 sfr_wr = 0;
  endtask
  // Read: data is registered, so two edges are allowed
  task rdr(input logic [7:0] a);
    sfr_addr = a;
    repeat (2) @(posedge mclk);
    #1 rd = sfr_rdata;
  endtask
  // One-cycle pulse on a wake or tick line
  task pulse(input bit tick);
    @(posedge mclk);
    #1 timer_tick = tick;
    wake_event = !tick;
    @(posedge mclk);
    #1 timer_tick = 0;
    wake_event = 0;
  endtask
  // Crystal modes take both pins, other live modes only the output
  function logic [7:0] exp_claim(input logic [2:0] m);
    return {6'h0, m[2:1] == 2'h3, m >= 3'h2};
  endfunction
  // Divided pulses in a 64-cycle window
  function logic [7:0] exp_pulses(input logic [1:0] f);
    return 8'h08 << f;
  endfunction
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, far beyond the roughly one thousand cycles expected
  initial
  begin
    #2000000 num_errors++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1;
    rdr(8'hb2);
    chk(rd, 8'hc0, "reset value");
    chk({7'h0, hf_osc_run}, 8'h01, "run at reset");
    rdr(8'hb1);
    chk(rd, 8'h00, "unmapped read");
    // Every divider code, random ignored bits and dither bit
    for (i = 0; i < 8; i++)
    begin
      d = ($random(seed) & 8'h5c) | (i % 4);
      wr(8'hb2, 8'h80 | d[7:0]);
      rdr(8'hb2);
      chk(rd, 8'hc0 | (d[7:0] & 8'h0b), "readback");
      n = 0;
      repeat (64)
      begin
        @(posedge mclk);
        #1 n += system_clock;
      end
      chk(n[7:0], exp_pulses(d[1:0]), "divider rate");
    end
    // Pin claims for every mode code; software skips them and sets pin kind
    for (i = 0; i < 8; i++)
    begin
      src_sel = i[2:0];
      repeat (3) @(posedge mclk);
      #1 chk({6'h0, cin, cout}, exp_claim(i[2:0]), "pin claim");
      chk({7'h0, pins_analog}, {7'h0, i[2]}, "pin kind");
    end
    wr(8'hb2, 8'h80);
    repeat (20) @(posedge mclk);
    #1 chk({6'h0, dither_step}, 8'h00, "no dither");
    chk({7'h0, dither_up}, 8'h01, "dither idle");
    // Dither: first step after 32 cycles, held 32, six up then six down
    wr(8'hb2, 8'h88);
    stp = dither_step;
    n = 0;
    while (dither_step === stp && n < 200)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n[7:0], 8'h20, "first step");
    stp = dither_step;
    n = 0;
    repeat (31)
    begin
      @(posedge mclk);
      #1 n += (dither_step !== stp);
    end
    chk(n[7:0], 8'h00, "step held");
    // Seventh step is the first one down, from the top to two
    repeat (177) @(posedge mclk);
    #1 chk({5'h0, dither_up, dither_step}, 8'h02, "falling half");
    repeat (176) @(posedge mclk);
    #1 chk({6'h0, dither_step}, {6'h0, stp}, "dither period");
    // Disable, then enable and wait for ready
    wr(8'hb2, 8'h00);
    rdr(8'hb2);
    chk(rd, 8'h00, "disabled");
    chk({7'h0, hf_osc_run}, 8'h00, "stopped");
    wr(8'hb2, 8'h80);
    rdr(8'hb2);
    chk({7'h0, rd[6]}, 8'h00, "not ready yet");
    n = 0;
    while (rd[6] !== 1'b1 && n < 40)
    begin
      rdr(8'hb2);
      n++;
    end
    chk(rd, 8'hc0, "ready again");
    // Sleep, non-timer wake, sync busy across three ticks
    wr(8'hb2, 8'ha0);
    chk({7'h0, hf_osc_run}, 8'h00, "asleep");
    rdr(8'hb2);
    chk({7'h0, rd[6]}, 8'h00, "ready in sleep");
    pulse(0);
    chk({7'h0, hf_osc_run}, 8'h01, "woken");
    rdr(8'hb2);
    chk({7'h0, rd[4]}, 8'h01, "sync busy");
    for (i = 0; i < 3; i++)
    begin
      pulse(1);
      rdr(8'hb2);
      chk({7'h0, rd[4]}, {7'h0, i < 2}, "sync after tick");
    end
    // Wake from the timer itself leaves sync busy clear
    wake_by_timer = 1;
    wr(8'hb2, 8'ha0);
    pulse(0);
    chk({7'h0, hf_osc_run}, 8'h01, "timer wake");
    rdr(8'hb2);
    chk({7'h0, rd[4]}, 8'h00, "no sync busy");
    wake_by_timer = 0;
    // Enable cleared while asleep: a later wake must not start it
    wr(8'hb2, 8'ha0);
    wr(8'hb2, 8'h00);
    pulse(0);
    chk({7'h0, hf_osc_run}, 8'h00, "off after wake");
    // Reset in mid-run brings back the power-up values
    rst_n = 0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1;
    rdr(8'hb2);
    chk(rd, 8'hc0, "value after reset");
    chk({7'h0, hf_osc_run}, 8'h01, "run after reset");
    finish_test;
  end
endmodule // tb
